// ===== logic/dfcc_pkg.sv
package dfcc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, low eight address bits decoded)
    // ------------------------------------------------------------
    localparam logic [7:0] DFCC_CTRL_OFS = 8'h00;
    localparam logic [7:0] DFCC_CAUSE_OFS = 8'h04;
    localparam logic [7:0] DFCC_STAT_OFS = 8'h08;
    localparam logic [7:0] DFCC_MASK_OFS = 8'h0C;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int DFCC_CTRL_W = 5;
    localparam int DFCC_CB_SUP_ON = 0;
    localparam int DFCC_CB_REP_AIS = 1;
    localparam int DFCC_CB_REP_SSF = 2;
    localparam int DFCC_CB_REP_TSF = 3;
    localparam int DFCC_CB_AIS_SEL = 4;
    localparam logic [DFCC_CTRL_W-1:0] DFCC_CTRL_RST = 5'h01;

    // ------------------------------------------------------------
    // Cause vector bit positions (cause, status and mask registers)
    // ------------------------------------------------------------
    localparam int DFCC_NCAUSE = 9;
    localparam int DFCC_C_LOS = 0;
    localparam int DFCC_C_DEG = 1;
    localparam int DFCC_C_FRM = 2;
    localparam int DFCC_C_JUS = 3;
    localparam int DFCC_C_PLM = 4;
    localparam int DFCC_C_AIS = 5;
    localparam int DFCC_C_SRV = 6;
    localparam int DFCC_C_OSF = 7;
    localparam int DFCC_C_TRL = 8;
    localparam logic [DFCC_NCAUSE-1:0] DFCC_CAUSE_RST = 9'h000;
    localparam logic [DFCC_NCAUSE-1:0] DFCC_STAT_RST = 9'h000;
    localparam logic [DFCC_NCAUSE-1:0] DFCC_MASK_RST = 9'h000;

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DFCC_ST_IDLE = 2'h1,
        DFCC_ST_WR = 2'h2
    } dfcc_state_e;

    function automatic logic dfcc_hit(input logic [7:0] a,
                                      input logic [7:0] ofs);
        return a == ofs;
    endfunction : dfcc_hit

endpackage : dfcc_pkg

// ===== logic/dfcc_cause_if.sv
`timescale 1ns/1ps
interface dfcc_cause_if;
    import dfcc_pkg::*;
    // Defects and incoming fail signals
    logic signal_loss_defect;
    logic trace_mismatch_defect;
    logic degraded_defect;
    logic alignment_loss_defect;
    logic justification_loss_defect;
    logic payload_mismatch_defect;
    logic alarm_indication_defect;
    logic trail_fail;
    logic server_fail;
    logic ordered_set_anomaly;
    logic code_group_fail;
    // Provisioning
    logic [DFCC_CTRL_W-1:0] ctrl;
    // Registered causes
    logic [DFCC_NCAUSE-1:0] cause;

    modport corr (
        input signal_loss_defect, trace_mismatch_defect, degraded_defect,
        input alignment_loss_defect, justification_loss_defect,
        input payload_mismatch_defect, alarm_indication_defect,
        input trail_fail, server_fail, ordered_set_anomaly,
        input code_group_fail, ctrl,
        output cause
    );
    modport top (
        output signal_loss_defect, trace_mismatch_defect, degraded_defect,
        output alignment_loss_defect, justification_loss_defect,
        output payload_mismatch_defect, alarm_indication_defect,
        output trail_fail, server_fail, ordered_set_anomaly,
        output code_group_fail, ctrl,
        input cause
    );
endinterface : dfcc_cause_if

// ===== logic/dfcc_correlator.sv
`timescale 1ns/1ps
module dfcc_correlator
    import dfcc_pkg::*;
(
    // Clock, reset, enable
    input logic core_clk_in,
    input logic rstn_in,
    input logic ce_in,
    // Defects, provisioning and causes
    dfcc_cause_if.corr cif
);

    logic [DFCC_NCAUSE-1:0] cause_nxt;
    logic ais_term;
    logic sup;

    // ------------------------------------------------------------
    // Cause expressions
    // ------------------------------------------------------------
    always_comb begin
        sup = cif.ctrl[DFCC_CB_SUP_ON];
        // Without own AIS detection the preceding trail fail stands in
        ais_term = cif.ctrl[DFCC_CB_AIS_SEL] ? cif.trail_fail
                                              : cif.alarm_indication_defect;
        cause_nxt = DFCC_CAUSE_RST;
        cause_nxt[DFCC_C_LOS] = sup && cif.signal_loss_defect;
        cause_nxt[DFCC_C_DEG] = sup && !cif.trace_mismatch_defect
                                && cif.degraded_defect;
        cause_nxt[DFCC_C_FRM] = cif.alignment_loss_defect && !ais_term
                                && !cif.payload_mismatch_defect && sup;
        cause_nxt[DFCC_C_JUS] = cif.justification_loss_defect && !ais_term
                                && !cif.payload_mismatch_defect && sup;
        cause_nxt[DFCC_C_PLM] = cif.payload_mismatch_defect
                                && !cif.trail_fail;
        cause_nxt[DFCC_C_AIS] = cif.alarm_indication_defect
                                && !cif.trail_fail
                                && !cif.payload_mismatch_defect
                                && cif.ctrl[DFCC_CB_REP_AIS];
        cause_nxt[DFCC_C_SRV] = sup && cif.server_fail
                                && cif.ctrl[DFCC_CB_REP_SSF];
        cause_nxt[DFCC_C_OSF] = (cif.ordered_set_anomaly
                                || cif.code_group_fail)
                                && !cif.trail_fail && sup;
        cause_nxt[DFCC_C_TRL] = sup && cif.trail_fail
                                && cif.ctrl[DFCC_CB_REP_TSF];
    end

    // ------------------------------------------------------------
    // Registered causes, no hysteresis
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cif.cause <= DFCC_CAUSE_RST;
        end else if (ce_in) begin
            cif.cause <= cause_nxt;
        end
    end

endmodule : dfcc_correlator

// ===== logic/dfcc_top.sv
// Contract
// - Each cause follows its expression exactly; nothing latched, held only while the clock enable is low.
// - Signal-loss cause = supervision on and signal-loss defect.
// - Degraded cause = supervision on, no trace mismatch, degraded defect.
// - Frame-loss cause = alignment loss, no AIS term, no PLM, supervision.
// - Justification cause = justification loss, no AIS term, no PLM, on.
// - Payload-mismatch cause = payload-mismatch defect and no trail fail.
// - AIS cause = AIS defect, no trail fail, no PLM, reporting enabled.
// - AIS reporting enable is software settable and resets to off.
// - Server-fail cause = supervision, server fail and its enable.
// - Server-fail reporting enable is software settable, resets off.
// - Ordered-set cause = (anomaly or code-group fail), no trail fail, on.
// - Trail-fail cause = supervision, trail fail input and its enable.
// - Without own AIS detection, trail fail replaces the AIS defect term.
// - Alignment-loss input carries frame, multiframe or pointer loss.
`timescale 1ns/1ps
module dfcc_top
    import dfcc_pkg::*;
(
    // Clock, reset, enable
    input logic core_clk_in,
    input logic rstn_in,
    input logic ce_in,
    // AHB-Lite slave
    input logic hsel_in,
    input logic [31:0] haddr_in,
    input logic [1:0] htrans_in,
    input logic hwrite_in,
    input logic [2:0] hsize_in,
    input logic [31:0] hwdata_in,
    input logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Defect detectors
    input logic signal_loss_defect_in,
    input logic trace_mismatch_defect_in,
    input logic degraded_defect_in,
    input logic alignment_loss_defect_in,
    input logic justification_loss_defect_in,
    input logic payload_mismatch_defect_in,
    input logic alarm_indication_defect_in,
    input logic trail_fail_in,
    input logic server_fail_in,
    input logic ordered_set_anomaly_in,
    input logic code_group_fail_in,
    // Fault causes to the failure filters
    output logic signal_loss_cause_out,
    output logic degraded_cause_out,
    output logic frame_loss_cause_out,
    output logic justification_loss_cause_out,
    output logic payload_mismatch_cause_out,
    output logic alarm_indication_cause_out,
    output logic server_fail_cause_out,
    output logic ordered_set_fail_cause_out,
    output logic trail_fail_cause_out,
    // Interrupt
    output logic irq_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dfcc_state_e state_r;
    logic [7:0] wr_addr_r;
    logic [DFCC_CTRL_W-1:0] ctrl_r;
    logic [DFCC_NCAUSE-1:0] stat_r;
    logic [DFCC_NCAUSE-1:0] stat_nxt;
    logic [DFCC_NCAUSE-1:0] mask_r;
    logic [DFCC_NCAUSE-1:0] cause_prev_r;
    logic [DFCC_NCAUSE-1:0] cause;
    logic [DFCC_NCAUSE-1:0] stat_clr;
    logic [31:0] rd_mux;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic irq_r;
    logic addr_ok;
    logic wr_go;

    dfcc_cause_if cif ();

    // ------------------------------------------------------------
    // Correlator hookup
    // ------------------------------------------------------------
    assign cif.signal_loss_defect = signal_loss_defect_in;
    assign cif.trace_mismatch_defect = trace_mismatch_defect_in;
    assign cif.degraded_defect = degraded_defect_in;
    assign cif.alignment_loss_defect = alignment_loss_defect_in;
    assign cif.justification_loss_defect = justification_loss_defect_in;
    assign cif.payload_mismatch_defect = payload_mismatch_defect_in;
    assign cif.alarm_indication_defect = alarm_indication_defect_in;
    assign cif.trail_fail = trail_fail_in;
    assign cif.server_fail = server_fail_in;
    assign cif.ordered_set_anomaly = ordered_set_anomaly_in;
    assign cif.code_group_fail = code_group_fail_in;
    assign cif.ctrl = ctrl_r;
    assign cause = cif.cause;

    dfcc_correlator u_corr (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .cif(cif.corr)
    );

    // ------------------------------------------------------------
    // Bus slave: reads zero wait, writes one wait state
    // ------------------------------------------------------------
    assign addr_ok = hsel_in && hready_in && htrans_in[1];
    assign wr_go = ce_in && (state_r == DFCC_ST_WR);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= DFCC_ST_IDLE;
            wr_addr_r <= 8'h00;
            hreadyout_r <= 1'b1;
        end else if (ce_in) begin
            case (state_r)
                DFCC_ST_IDLE: begin
                    if (addr_ok && hwrite_in) begin
                        state_r <= DFCC_ST_WR;
                        wr_addr_r <= haddr_in[7:0];
                        hreadyout_r <= 1'b0;
                    end
                end
                DFCC_ST_WR: begin
                    state_r <= DFCC_ST_IDLE;
                    hreadyout_r <= 1'b1;
                end
                default: begin
                    state_r <= DFCC_ST_IDLE;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data, captured in the address phase
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dfcc_hit(haddr_in[7:0], DFCC_CTRL_OFS)) begin
            rd_mux[DFCC_CTRL_W-1:0] = ctrl_r;
        end else if (dfcc_hit(haddr_in[7:0], DFCC_CAUSE_OFS)) begin
            rd_mux[DFCC_NCAUSE-1:0] = cause;
        end else if (dfcc_hit(haddr_in[7:0], DFCC_STAT_OFS)) begin
            rd_mux[DFCC_NCAUSE-1:0] = stat_r;
        end else if (dfcc_hit(haddr_in[7:0], DFCC_MASK_OFS)) begin
            rd_mux[DFCC_NCAUSE-1:0] = mask_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            if (state_r == DFCC_ST_IDLE && addr_ok && !hwrite_in) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Provisioning: supervision and reporting enables
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r <= DFCC_CTRL_RST;
        end else if (wr_go && dfcc_hit(wr_addr_r, DFCC_CTRL_OFS)) begin
            ctrl_r <= hwdata_in[DFCC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_r <= DFCC_MASK_RST;
        end else if (wr_go && dfcc_hit(wr_addr_r, DFCC_MASK_OFS)) begin
            mask_r <= hwdata_in[DFCC_NCAUSE-1:0];
        end
    end

    // ------------------------------------------------------------
    // Sticky status: a cause rising sets, write one clears, set wins
    // ------------------------------------------------------------
    always_comb begin
        stat_clr = '0;
        if (wr_go && dfcc_hit(wr_addr_r, DFCC_STAT_OFS)) begin
            stat_clr = hwdata_in[DFCC_NCAUSE-1:0];
        end
        stat_nxt = (stat_r & ~stat_clr) | (cause & ~cause_prev_r);
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_r <= DFCC_STAT_RST;
            cause_prev_r <= DFCC_CAUSE_RST;
        end else if (ce_in) begin
            stat_r <= stat_nxt;
            cause_prev_r <= cause;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_r <= 1'b0;
        end else if (ce_in) begin
            irq_r <= |(stat_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata_out = hrdata_r;
    assign hreadyout_out = hreadyout_r;
    assign hresp_out = 1'b0;
    assign irq_out = irq_r;
    assign signal_loss_cause_out = cause[DFCC_C_LOS];
    assign degraded_cause_out = cause[DFCC_C_DEG];
    assign frame_loss_cause_out = cause[DFCC_C_FRM];
    assign justification_loss_cause_out = cause[DFCC_C_JUS];
    assign payload_mismatch_cause_out = cause[DFCC_C_PLM];
    assign alarm_indication_cause_out = cause[DFCC_C_AIS];
    assign server_fail_cause_out = cause[DFCC_C_SRV];
    assign ordered_set_fail_cause_out = cause[DFCC_C_OSF];
    assign trail_fail_cause_out = cause[DFCC_C_TRL];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_signal_loss: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> signal_loss_cause_out ==
            ($past(ctrl_r[DFCC_CB_SUP_ON]) && $past(signal_loss_defect_in)))
        else $error("signal loss cause wrong");

    a_degraded_cause: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> degraded_cause_out ==
            ($past(ctrl_r[DFCC_CB_SUP_ON])
             && !$past(trace_mismatch_defect_in)
             && $past(degraded_defect_in)))
        else $error("degraded cause wrong");

    a_frame_loss: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> frame_loss_cause_out ==
            ($past(alignment_loss_defect_in)
             && !($past(ctrl_r[DFCC_CB_AIS_SEL]) ? $past(trail_fail_in)
                  : $past(alarm_indication_defect_in))
             && !$past(payload_mismatch_defect_in)
             && $past(ctrl_r[DFCC_CB_SUP_ON])))
        else $error("frame loss cause wrong");

    a_ais_substitute: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ce_in && ctrl_r[DFCC_CB_AIS_SEL] && trail_fail_in)
        |=> !frame_loss_cause_out && !justification_loss_cause_out)
        else $error("trail fail did not mask alignment causes");

    a_justification: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> justification_loss_cause_out ==
            ($past(justification_loss_defect_in)
             && !($past(ctrl_r[DFCC_CB_AIS_SEL]) ? $past(trail_fail_in)
                  : $past(alarm_indication_defect_in))
             && !$past(payload_mismatch_defect_in)
             && $past(ctrl_r[DFCC_CB_SUP_ON])))
        else $error("justification loss cause wrong");

    a_payload_mismatch: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> payload_mismatch_cause_out ==
            ($past(payload_mismatch_defect_in) && !$past(trail_fail_in)))
        else $error("payload mismatch cause wrong");

    a_alarm_ind: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> alarm_indication_cause_out ==
            ($past(alarm_indication_defect_in) && !$past(trail_fail_in)
             && !$past(payload_mismatch_defect_in)
             && $past(ctrl_r[DFCC_CB_REP_AIS])))
        else $error("alarm indication cause wrong");

    a_server_fail: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> server_fail_cause_out ==
            ($past(ctrl_r[DFCC_CB_SUP_ON]) && $past(server_fail_in)
             && $past(ctrl_r[DFCC_CB_REP_SSF])))
        else $error("server fail cause wrong");

    a_ordered_set: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> ordered_set_fail_cause_out ==
            (($past(ordered_set_anomaly_in) || $past(code_group_fail_in))
             && !$past(trail_fail_in) && $past(ctrl_r[DFCC_CB_SUP_ON])))
        else $error("ordered set cause wrong");

    a_trail_fail: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> trail_fail_cause_out ==
            ($past(ctrl_r[DFCC_CB_SUP_ON]) && $past(trail_fail_in)
             && $past(ctrl_r[DFCC_CB_REP_TSF])))
        else $error("trail fail cause wrong");

    a_enable_by_write: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !$stable(ctrl_r) |-> $past(wr_go)
            && $past(wr_addr_r) == DFCC_CTRL_OFS)
        else $error("provisioning changed without a write");

    a_cause_frozen: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(cause))
        else $error("causes moved while disabled");

    a_sticky_status: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ce_in && cause[DFCC_C_LOS] && !cause_prev_r[DFCC_C_LOS])
        |=> stat_r[DFCC_C_LOS])
        else $error("status did not capture rising cause");

    a_irq_level: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ce_in |=> irq_out == |($past(stat_nxt) & $past(mask_r)))
        else $error("interrupt level wrong");

    a_write_wait: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ce_in && state_r == DFCC_ST_IDLE && addr_ok && hwrite_in)
        |=> !hreadyout_out ##1 (hreadyout_out || !ce_in))
        else $error("write wait state wrong");

endmodule : dfcc_top

// ===== bench/dfcc_defect_model.sv
`timescale 1ns/1ps
module dfcc_defect_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Requested defect levels
    input wire logic [10:0] pattern_in,
    // Defect levels to the correlator
    output logic [10:0] defect_out
);
    // Detectors launch their levels on the clock, never mid-cycle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            defect_out <= 11'h000;
        end else begin
            defect_out <= pattern_in;
        end
    end
endmodule : dfcc_defect_model

// ===== bench/dfcc_top_bench.sv
`timescale 1ns/1ps
module dfcc_top_bench;
    import dfcc_pkg::*;
    logic clk, rstn, ce, hsel, hwrite, hready, hresp, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [10:0] pat, d;
    logic [8:0] pins;
    int error_cnt = 0;
    int checks_done = 0;

    dfcc_defect_model MDL (.core_clk_in(clk), .rstn_in(rstn),
        .pattern_in(pat), .defect_out(d));
    dfcc_top DUT (.core_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp),
        .signal_loss_defect_in(d[0]), .trace_mismatch_defect_in(d[1]),
        .degraded_defect_in(d[2]), .alignment_loss_defect_in(d[3]),
        .justification_loss_defect_in(d[4]),
        .payload_mismatch_defect_in(d[5]),
        .alarm_indication_defect_in(d[6]), .trail_fail_in(d[7]),
        .server_fail_in(d[8]), .ordered_set_anomaly_in(d[9]),
        .code_group_fail_in(d[10]), .signal_loss_cause_out(pins[0]),
        .degraded_cause_out(pins[1]), .frame_loss_cause_out(pins[2]),
        .justification_loss_cause_out(pins[3]),
        .payload_mismatch_cause_out(pins[4]),
        .alarm_indication_cause_out(pins[5]),
        .server_fail_cause_out(pins[6]),
        .ordered_set_fail_cause_out(pins[7]),
        .trail_fail_cause_out(pins[8]), .irq_out(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------
    // Shared helpers
    // ----------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e, "register read");
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    function automatic logic [8:0] expect_cause(input logic [4:0] c,
                                                input logic [10:0] v);
        logic a;
        a = c[4] ? v[7] : v[6];
        expect_cause[0] = c[0] & v[0];
        expect_cause[1] = c[0] & !v[1] & v[2];
        expect_cause[2] = v[3] & !a & !v[5] & c[0];
        expect_cause[3] = v[4] & !a & !v[5] & c[0];
        expect_cause[4] = v[5] & !v[7];
        expect_cause[5] = v[6] & !v[7] & !v[5] & c[1];
        expect_cause[6] = c[0] & v[8] & c[2];
        expect_cause[7] = (v[9] | v[10]) & !v[7] & c[0];
        expect_cause[8] = c[0] & v[7] & c[3];
    endfunction : expect_cause

    // ----------------
    // Scenarios
    // ----------------
    task automatic test_reset;
        chk({23'h0, pins}, 32'h0, "causes after reset");
        rdchk(DFCC_CTRL_OFS, 32'h1);
        rdchk(DFCC_STAT_OFS, 32'h0);
        rdchk(DFCC_MASK_OFS, 32'h0);
        rdchk(8'h10, 32'h0);
        bus(1'b1, DFCC_CTRL_OFS, 32'h1F);
        rdchk(DFCC_CTRL_OFS, 32'h1F);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_causes;
        logic [4:0] c;
        logic [10:0] v;
        for (int i = 0; i < 96; i++) begin
            c = 5'(i) ^ 5'(i >> 5);
            v = 11'(i * 1447) ^ 11'(i >> 2);
            bus(1'b1, DFCC_CTRL_OFS, {27'h0, c});
            pat <= v;
            tick(3);
            chk({23'h0, pins}, {23'h0, expect_cause(c, v)}, "pins");
            rdchk(DFCC_CAUSE_OFS, {23'h0, expect_cause(c, v)});
        end
        $display("test_causes done");
    endtask : test_causes

    // Clock enable low must hold the causes while the defects move
    task automatic test_freeze;
        bus(1'b1, DFCC_CTRL_OFS, 32'h1);
        pat <= 11'h000;
        tick(3);
        ce <= 1'b0;
        pat <= 11'h001;
        tick(4);
        chk({23'h0, pins}, 32'h0, "causes frozen");
        ce <= 1'b1;
        tick(3);
        chk({23'h0, pins}, 32'h1, "causes resumed");
        $display("test_freeze done");
    endtask : test_freeze

    task automatic test_irq;
        pat <= 11'h000;
        bus(1'b1, DFCC_CTRL_OFS, 32'h1);
        bus(1'b1, DFCC_STAT_OFS, 32'h1FF);
        rdchk(DFCC_STAT_OFS, 32'h0);
        bus(1'b1, DFCC_MASK_OFS, 32'h1);
        pat <= 11'h001;
        tick(4);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rdchk(DFCC_STAT_OFS, 32'h1);
        bus(1'b1, DFCC_MASK_OFS, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0, "irq masked");
        bus(1'b1, DFCC_MASK_OFS, 32'h1);
        pat <= 11'h000;
        tick(3);
        chk({31'h0, irq}, 32'h1, "irq sticky");
        chk({23'h0, pins}, 32'h0, "cause not latched");
        bus(1'b1, DFCC_CAUSE_OFS, 32'h1FF);
        rdchk(DFCC_CAUSE_OFS, 32'h0);
        bus(1'b1, DFCC_STAT_OFS, 32'h1);
        tick(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rdchk(DFCC_STAT_OFS, 32'h0);
        $display("test_irq done");
    endtask : test_irq

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200us;
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        hsel = 1'b1;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        pat = 11'h000;
        tick(10);
        rstn <= 1'b1;
        test_reset;
        test_causes;
        test_freeze;
        test_irq;
        finish_test;
    end
endmodule : dfcc_top_bench
